// [spf_pkg.sv]
// Package: constants for the speech payload framer
package spf_pkg;
   localparam int SIZE_W = 12;
   localparam int RATE_W = 16;
   // APB register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PAYLOAD = 8'h04;
   localparam logic [7:0] ADDR_CLASS = 8'h08;
   localparam logic [7:0] ADDR_RATE = 8'h0C;
   localparam logic [7:0] ADDR_SILENCE = 8'h10;
   localparam logic [7:0] ADDR_SILENCE_HI = 8'h14;
   localparam logic [7:0] ADDR_REDUND = 8'h18;
   localparam logic [7:0] ADDR_TSTAMP = 8'h1C;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   // CTRL fields
   localparam int CTRL_FRAME_BIT = 0;
   localparam int CTRL_TALK_BIT = 1;
   localparam int CTRL_SIZE_LSB = 4;
   // Timestamp
   localparam int TS_CLOCK_HZ = 16000;
   localparam int FRAME_MS = 20;
   localparam logic [31:0] TS_STEP = 32'(TS_CLOCK_HZ * FRAME_MS / 1000);
   localparam logic [31:0] TS_RESET = 32'h0000_0000;
   // Special sizes
   localparam logic [SIZE_W-1:0] SIZE_SILENCE = 12'h030;
   localparam logic [SIZE_W-1:0] SIZE_SPECIAL = 12'h038;
   localparam logic [SIZE_W-1:0] SIZE_CHAN_AWARE = 12'h108;
   localparam int DESC_BITS = 48;
   localparam int CHAN_AWARE_BITS = 264;
   localparam int MREQ_W = 3;

   typedef enum logic [2:0] {
      SPF_CLS_INVALID = 3'h0,
      SPF_CLS_PRIMARY = 3'h1,
      SPF_CLS_PRIM_SILENCE = 3'h2,
      SPF_CLS_INTEROP = 3'h3,
      SPF_CLS_PRIM_LOWRATE = 3'h4,
      SPF_CLS_INTEROP_SILENCE = 3'h5
   } spf_class_type;

   typedef enum logic [2:0] {
      SPF_RED_NONE = 3'h0,
      SPF_RED_TRANSFORM_FD = 3'h1,
      SPF_RED_TRANSFORM_TD_A = 3'h2,
      SPF_RED_TRANSFORM_TD_B = 3'h3,
      SPF_RED_ALL_PREDICTIVE = 3'h4,
      SPF_RED_NON_PREDICTIVE = 3'h5,
      SPF_RED_GENERIC_PREDICTIVE = 3'h6,
      SPF_RED_NOISE_EXCITED = 3'h7
   } spf_redund_type;

   // Rate in units of 10 bps
   function automatic logic [RATE_W-1:0] spf_rate(input logic [SIZE_W-1:0] s,
         output logic prim, output logic interop);
      prim = 1'b1;
      interop = 1'b0;
      case (s)
         12'h030: spf_rate = 16'h00F0;
         12'h038: spf_rate = 16'h0118;
         12'h090: spf_rate = 16'h02D0;
         12'h0A0: spf_rate = 16'h0320;
         12'h0C0: spf_rate = 16'h03C0;
         12'h108: spf_rate = 16'h0528;
         12'h148: spf_rate = 16'h0668;
         12'h1E8: spf_rate = 16'h0988;
         12'h280: spf_rate = 16'h0C80;
         12'h3C0: spf_rate = 16'h12C0;
         12'h500: spf_rate = 16'h1900;
         12'h780: spf_rate = 16'h2580;
         12'hA00: spf_rate = 16'h3200;
         default: begin
            prim = 1'b0;
            interop = 1'b1;
            case (s)
               12'h088: spf_rate = 16'h0294;
               12'h0B8: spf_rate = 16'h0375;
               12'h100: spf_rate = 16'h04F1;
               12'h120: spf_rate = 16'h0591;
               12'h140: spf_rate = 16'h0631;
               12'h170: spf_rate = 16'h0721;
               12'h190: spf_rate = 16'h07C1;
               12'h1D0: spf_rate = 16'h0901;
               12'h1E0: spf_rate = 16'h0951;
               default: begin
                  spf_rate = 16'h0000;
                  interop = 1'b0;
               end
            endcase
         end
      endcase
   endfunction
endpackage

// [spf_size_classifier.sv]
// Size classifier: payload size in bits to mode and rate
`timescale 1ns/1ps
module spf_size_classifier (
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic valid_i,
   input wire logic [spf_pkg::SIZE_W-1:0] size_i,
   input wire logic first_bit_i,
   output spf_pkg::spf_class_type class_o,
   output logic [spf_pkg::RATE_W-1:0] rate_o,
   output logic done_o
);
   import spf_pkg::*;
   logic prim;
   logic interop;
   logic [RATE_W-1:0] rate;
   spf_class_type cls;

   always_comb begin
      rate = spf_rate(size_i, prim, interop);
      if (size_i == SIZE_SILENCE)
         cls = SPF_CLS_PRIM_SILENCE;
      else if (size_i == SIZE_SPECIAL)
         cls = first_bit_i ? SPF_CLS_INTEROP_SILENCE
               : SPF_CLS_PRIM_LOWRATE;
      else if (prim)
         cls = SPF_CLS_PRIMARY;
      else if (interop)
         cls = SPF_CLS_INTEROP;
      else
         cls = SPF_CLS_INVALID;
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         class_o <= SPF_CLS_INVALID;
         rate_o <= 16'h0000;
         done_o <= 1'b0;
      end else begin
         done_o <= valid_i;
         if (valid_i) begin
            class_o <= cls;
            rate_o <= rate;
         end
      end
   end
endmodule // spf_size_classifier

// [spf_payload_mem.sv]
// Payload memory: holds all nine payload words, first to last
`timescale 1ns/1ps
module spf_payload_mem #(
   parameter int DEPTH = 9
) (
   input wire logic CLK_I,
   input wire logic we_i,
   input wire logic [3:0] waddr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] raddr_i,
   output logic [31:0] rdata_o
);
   logic [31:0] mem [DEPTH];

   always_ff @(posedge CLK_I) begin
      if (we_i && (int'(waddr_i) < DEPTH))
         mem[waddr_i] <= wdata_i;
   end

   always_ff @(posedge CLK_I) begin
      rdata_o <= (int'(raddr_i) < DEPTH) ? mem[raddr_i] : 32'h0000_0000;
   end
endmodule // spf_payload_mem

// [spf_top.sv]
// Speech payload framer: classify, parse descriptors, RTP timing
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module spf_top (
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output logic DECODE_VALID_O,
   output logic FRAME_INVALID_O,
   output logic MARKER_O,
   output logic [31:0] TIMESTAMP_O
);
   import spf_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // APB access decode
   logic wr_acc;
   logic rd_acc;
   logic mapped;
   logic [31:0] ctrl_r;
   logic [31:0] rd_nxt;
   logic [31:0] mem_rdata;
   logic mem_we;
   logic [3:0] mem_waddr;
   logic [3:0] mem_raddr;
   logic busy_r;
   logic [3:0] walk_r;
   logic [31:0] head_r;
   logic [31:0] tail_r;
   logic [31:0] prev_r;
   spf_class_type cls;
   logic [RATE_W-1:0] rate;
   logic cls_done;
   logic [SIZE_W-1:0] size_r;
   logic [47:0] desc_r;
   logic [4:0] ca_head_r;
   logic [1:0] ca_off_code_r;
   spf_redund_type ca_type_r;
   logic [2:0] ca_offset;
   logic [2:0] mreq_r;
   logic talk_r;
   logic [31:0] ts_r;
   logic marker_r;
   logic invalid_r;
   logic valid_r;

   assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
   assign rd_acc = PSEL_I && PENABLE_I && !PWRITE_I;
   assign mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= ADDR_STATUS)
         || ((PADDR_I >= 8'h40) && (PADDR_I < 8'h64)
         && (PADDR_I[1:0] == 2'h0));
   // Zero wait states: the access phase always completes at once
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

   ////////////////////////////////////////////////////////////////////////
   // Payload window: words 0x40..0x60, MSB-first bit order
   assign mem_we = wr_acc && (PADDR_I >= 8'h40) && (PADDR_I < 8'h64);
   assign mem_waddr = 4'(PADDR_I[5:2]);
   assign mem_raddr = busy_r ? walk_r : 4'(PADDR_I[5:2]);

   spf_payload_mem #(.DEPTH(9)) u_mem (
      .CLK_I(CLK_I),
      .we_i(mem_we),
      .waddr_i(mem_waddr),
      .wdata_i(PWDATA_I),
      .raddr_i(mem_raddr),
      .rdata_o(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Control register: frame strobe, talkspurt start, payload size
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I)
         ctrl_r <= 32'h0000_0000;
      else if (wr_acc && PADDR_I == ADDR_CTRL)
         ctrl_r <= {16'h0000, PWDATA_I[15:4], 2'h0, PWDATA_I[1], 1'b0};
      else
         ctrl_r[CTRL_FRAME_BIT] <= 1'b0;
   end

   assign size_r = ctrl_r[CTRL_SIZE_LSB +: SIZE_W];

   ////////////////////////////////////////////////////////////////////////
   // Gather head word, and last 264-bit frame word for channel-aware use
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         busy_r <= 1'b0;
         walk_r <= 4'h0;
         head_r <= 32'h0000_0000;
         tail_r <= 32'h0000_0000;
         prev_r <= 32'h0000_0000;
      end else if (wr_acc && PADDR_I == ADDR_CTRL && PWDATA_I[CTRL_FRAME_BIT]
            && !busy_r) begin
         busy_r <= 1'b1;
         walk_r <= 4'h0;
      end else if (busy_r) begin
         // Read data lags the address by one cycle; word 1 feeds the
         // descriptor's low 16 bits
         if (walk_r == 4'h2)
            prev_r <= mem_rdata;
         if (walk_r == 4'h1)
            head_r <= mem_rdata;
         if (walk_r == 4'h9) begin
            tail_r <= mem_rdata;
            busy_r <= 1'b0;
         end
         walk_r <= walk_r + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Classification starts when the walk finishes
   logic cls_go;
   assign cls_go = busy_r && (walk_r == 4'h9);

   spf_size_classifier u_cls (
      .CLK_I(CLK_I),
      .RSTN_I(RSTN_I),
      .valid_i(cls_go),
      .size_i(size_r),
      .first_bit_i(head_r[31]),
      .class_o(cls),
      .rate_o(rate),
      .done_o(cls_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Field parsing
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         desc_r <= 48'h0000_0000_0000;
         ca_head_r <= 5'h00;
         ca_off_code_r <= 2'h0;
         ca_type_r <= SPF_RED_NONE;
         mreq_r <= 3'h7;
      end else if (cls_done) begin
         // Descriptor occupies the first 48 payload bits, MSB first
         desc_r <= {head_r, prev_r[31:16]};
         ca_head_r <= head_r[31:27];
         // Bit 263 is the last: word 8 bits 31..24 hold bits 256..263
         ca_off_code_r <= tail_r[28:27];
         ca_type_r <= spf_redund_type'(tail_r[26:24]);
         if (cls == SPF_CLS_INTEROP)
            mreq_r <= head_r[31 -: MREQ_W];
         else
            mreq_r <= 3'h7;
      end
   end

   // Offsets 2, 3, 5, 7 in code order
   always_comb begin
      case (ca_off_code_r)
         2'h0: ca_offset = 3'h2;
         2'h1: ca_offset = 3'h3;
         2'h2: ca_offset = 3'h5;
         default: ca_offset = 3'h7;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Descriptor decode views
   logic d_linpred;
   logic d_super_wb;
   logic d_core16k;
   logic [2:0] d_hang;
   logic [28:0] d_spec;
   logic [6:0] d_energy;
   logic [5:0] d_env;
   logic [3:0] d_hb_energy;
   logic [1:0] d_fd_bw;
   logic d_fd_rate;
   logic [6:0] d_fd_gain;
   assign d_linpred = desc_r[47];
   assign d_super_wb = desc_r[46];
   assign d_core16k = desc_r[45];
   assign d_hang = desc_r[44:42];
   assign d_spec = desc_r[41:13];
   assign d_energy = desc_r[12:6];
   assign d_env = d_super_wb ? 6'h00 : desc_r[5:0];
   assign d_hb_energy = d_super_wb ? desc_r[5:2] : 4'h0;
   assign d_fd_bw = desc_r[46:45];
   assign d_fd_rate = desc_r[44];
   assign d_fd_gain = desc_r[43:37];

   ////////////////////////////////////////////////////////////////////////
   // RTP timestamp and marker
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ts_r <= TS_RESET;
         marker_r <= 1'b0;
         talk_r <= 1'b0;
         invalid_r <= 1'b0;
         valid_r <= 1'b0;
      end else begin
         valid_r <= 1'b0;
         if (cls_go)
            talk_r <= ctrl_r[CTRL_TALK_BIT];
         if (cls_done) begin
            ts_r <= ts_r + TS_STEP;
            marker_r <= talk_r;
            invalid_r <= (cls == SPF_CLS_INVALID);
            valid_r <= (cls != SPF_CLS_INVALID);
         end
      end
   end

   assign TIMESTAMP_O = ts_r;
   assign MARKER_O = marker_r;
   assign FRAME_INVALID_O = invalid_r;
   assign DECODE_VALID_O = valid_r;

   ////////////////////////////////////////////////////////////////////////
   // Read mux; flag zero means the payload decodes as plain 13.2 kbps
   logic ca_flag;
   assign ca_flag = ca_head_r[0];
   always_comb begin
      case (PADDR_I)
         ADDR_CTRL: rd_nxt = ctrl_r;
         ADDR_CLASS: rd_nxt = {25'h0, mreq_r, 1'b0, 3'(cls)};
         ADDR_RATE: rd_nxt = {16'h0000, rate};
         ADDR_PAYLOAD: rd_nxt = UNMAPPED_DATA;
         ADDR_SILENCE: rd_nxt = {d_linpred, d_super_wb, d_core16k, d_hang,
               d_energy, d_env, d_hb_energy, 2'h0, d_fd_gain};
         ADDR_SILENCE_HI: rd_nxt = {d_fd_bw, d_fd_rate, d_spec};
         ADDR_REDUND: rd_nxt = {16'h0000, ca_head_r, ca_flag,
               ca_offset, ca_off_code_r, 2'h0, 3'(ca_type_r)};
         ADDR_TSTAMP: rd_nxt = ts_r;
         ADDR_STATUS: rd_nxt = {28'h0, busy_r, marker_r, invalid_r,
               valid_r};
         default: rd_nxt = mapped ? mem_rdata : UNMAPPED_DATA;
      endcase
   end

   always_comb begin
      PRDATA_O = rd_acc ? rd_nxt : 32'h0000_0000;
   end
endmodule // spf_top

// [spf_top_chk.sv]
// Checker: port-level properties of the speech payload framer
`timescale 1ns/1ps
module spf_top_chk
   import spf_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic DECODE_VALID_O,
   input wire logic FRAME_INVALID_O,
   input wire logic MARKER_O,
   input wire logic [31:0] TIMESTAMP_O
);
   logic talk_r;
   wire logic acc = PSEL_I && PENABLE_I;
   wire logic go = acc && PWRITE_I && PADDR_I == ADDR_CTRL && PWDATA_I[0];
   ////////////////////////////////////////////////////////////////////////////
   // Talkspurt flag of the frame in flight, for the marker check
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         talk_r <= 1'b0;
      end else if (go) begin
         talk_r <= PWDATA_I[CTRL_TALK_BIT];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   sequence go_s;
      go && !PSLVERR_O;
   endsequence
   sequence done_s;
      DECODE_VALID_O || FRAME_INVALID_O;
   endsequence
   pready_high_a: assert property (acc |-> PREADY_O)
      else $error("access not answered at once");
   err_in_access_a: assert property (PSLVERR_O |-> acc)
      else $error("error flag outside access phase");
   bad_addr_a: assert property (acc && (PADDR_I[1:0] != 2'h0 ||
      PADDR_I > 8'h60) |-> PSLVERR_O && PRDATA_O == 32'h0)
      else $error("bad address not refused");
   rdata_idle_a: assert property (!(acc && !PWRITE_I) |-> PRDATA_O == 32'h0)
      else $error("read data outside read access");
   valid_pulse_a: assert property (DECODE_VALID_O |=> !DECODE_VALID_O)
      else $error("decode valid longer than one cycle");
   valid_excl_a: assert property (DECODE_VALID_O |-> !FRAME_INVALID_O)
      else $error("valid and invalid together");
   frame_quiet_a: assert property (go_s |=> !DECODE_VALID_O [*6])
      else $error("result too early");
   frame_answer_a: assert property (go_s |-> ##[8:20] done_s)
      else $error("no frame result");
   marker_talk_a: assert property ($rose(DECODE_VALID_O) |=>
      MARKER_O == talk_r)
      else $error("marker differs from talkspurt start");
   ts_step_a: assert property ($changed(TIMESTAMP_O) |->
      TIMESTAMP_O == $past(TIMESTAMP_O) + TS_STEP)
      else $error("timestamp step wrong");
endmodule // spf_top_chk

bind spf_top spf_top_chk spf_top_chk_i (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
   .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .DECODE_VALID_O(DECODE_VALID_O), .FRAME_INVALID_O(FRAME_INVALID_O),
   .MARKER_O(MARKER_O), .TIMESTAMP_O(TIMESTAMP_O));

// [spf_xport_mdl.sv]
// Transport-side model: lays payload words out as the wire carries them
`timescale 1ns/1ps
module spf_xport_mdl (
   input wire logic [4:0] head_i,
   input wire logic [1:0] offs_i,
   input wire logic [2:0] kind_i,
   output logic [31:0] word0_o,
   output logic [31:0] word8_o
);
   // First payload bit sits left-most, no payload header before it
   assign word0_o = {head_i, 27'h5A5A5A5};
   // Filler toggles so stale bits never look like a field
   assign word8_o = {3'h5, offs_i, kind_i, 24'hC3C3C3};
endmodule // spf_xport_mdl

// [tb_top.sv]
// Testbench: frame classification, field parsing and RTP timing
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %0t got %0h want %0h", $time, g, e); end end
module tb_top;
   import spf_pkg::*;
   logic CLK_I, RSTN_I, PSEL_I, PENABLE_I, PWRITE_I;
   logic [7:0] PADDR_I;
   logic [31:0] PWDATA_I, PRDATA_O, TIMESTAMP_O, w0, w8, rdat, ts_exp;
   logic PREADY_O, PSLVERR_O, DECODE_VALID_O, FRAME_INVALID_O, MARKER_O;
   logic [4:0] head;
   logic [1:0] offs;
   logic [2:0] kind;
   logic rerr, seen_v;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   spf_top spf_top_i (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
      .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
      .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
      .PSLVERR_O(PSLVERR_O), .DECODE_VALID_O(DECODE_VALID_O),
      .FRAME_INVALID_O(FRAME_INVALID_O), .MARKER_O(MARKER_O),
      .TIMESTAMP_O(TIMESTAMP_O));
   spf_xport_mdl spf_xport_mdl_i (.head_i(head), .offs_i(offs),
      .kind_i(kind), .word0_o(w0), .word8_o(w8));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      CLK_I = 1'b0;
      forever #20 CLK_I = ~CLK_I;
   end
   // Pulse is one cycle wide, so it is caught here rather than polled
   always @(posedge CLK_I) begin
      cyc++;
      if (DECODE_VALID_O === 1'b1) seen_v <= 1'b1;
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge CLK_I);
      PSEL_I <= 1'b1;
      PENABLE_I <= 1'b0;
      PWRITE_I <= wr;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge CLK_I);
      PENABLE_I <= 1'b1;
      do @(posedge CLK_I); while (PREADY_O !== 1'b1);
      rdat = PRDATA_O;
      rerr = PSLVERR_O;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
   endtask
   task automatic frame(input logic [11:0] sz, input logic talk);
      #1;
      apb(1'b1, 8'h40, w0);
      apb(1'b1, 8'h60, w8);
      seen_v <= 1'b0;
      apb(1'b1, ADDR_CTRL, {16'h0, sz, 2'h0, talk, 1'b1});
      do apb(1'b0, ADDR_STATUS, 32'h0); while (rdat[3] !== 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic reset_vals();
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rdat, 32'h0);
      `CHK(TIMESTAMP_O, TS_RESET);
   endtask
   // Entry: class, size in bits, rate in 10 bps units
   task automatic cls_table();
      logic [31:0] t [23] = '{32'h1090_02D0, 32'h10A0_0320, 32'h10C0_03C0,
         32'h1108_0528, 32'h1148_0668, 32'h11E8_0988, 32'h1280_0C80,
         32'h13C0_12C0, 32'h1500_1900, 32'h1780_2580, 32'h1A00_3200,
         32'h2030_00F0, 32'h4038_0118, 32'h5038_0118, 32'h3088_0294,
         32'h30B8_0375, 32'h3100_04F1, 32'h3120_0591, 32'h3140_0631,
         32'h3170_0721, 32'h3190_07C1, 32'h31D0_0901, 32'h31E0_0951};
      for (int i = 0; i < 23; i++) begin
         head = (t[i][30:28] == 3'h3) ? 5'h14 : {t[i][30:28] == 3'h5, 4'h0};
         frame(t[i][27:16], i[0]);
         ts_exp += TS_STEP;
         apb(1'b0, ADDR_CLASS, 32'h0);
         `CHK(rdat[2:0], t[i][30:28]);
         if (t[i][30:28] == 3'h3) `CHK(rdat[6:4], 3'h5);
         apb(1'b0, ADDR_RATE, 32'h0);
         `CHK(rdat[15:0], t[i][15:0]);
         `CHK(seen_v, 1'b1);
         `CHK(FRAME_INVALID_O, 1'b0);
         `CHK(MARKER_O, i[0]);
         `CHK(TIMESTAMP_O, ts_exp);
      end
   endtask
   task automatic chan_aware();
      logic [2:0] oexp [4] = '{3'h2, 3'h3, 3'h5, 3'h7};
      for (int k = 0; k < 8; k++) begin
         kind = k[2:0];
         offs = k[1:0];
         head = 5'h0B ^ {2'h0, k[2:0]};
         frame(SIZE_CHAN_AWARE, 1'b0);
         ts_exp += TS_STEP;
         apb(1'b0, ADDR_REDUND, 32'h0);
         `CHK(rdat[2:0], kind);
         `CHK(rdat[9:7], oexp[k % 4]);
         `CHK(rdat[15:11], head);
         `CHK(rdat[10], head[0]);
         apb(1'b0, ADDR_RATE, 32'h0);
         `CHK(rdat[15:0], 16'h0528);
      end
   endtask
   // Super-wideband then wideband descriptor, second word shared
   task automatic silence_desc();
      logic [4:0] hd [2] = '{5'h1A, 5'h12};
      logic [31:0] lo [2] = '{32'hD780_1E2D, 32'h9787_E02D};
      logic [31:0] hi [2] = '{32'hAD2D_2D2C, 32'h2D2D_2D2C};
      apb(1'b1, 8'h44, 32'h9C3F_0000);
      for (int j = 0; j < 2; j++) begin
         head = hd[j];
         frame(SIZE_SILENCE, 1'b0);
         ts_exp += TS_STEP;
         apb(1'b0, ADDR_SILENCE, 32'h0);
         `CHK(rdat, lo[j]);
         apb(1'b0, ADDR_SILENCE_HI, 32'h0);
         `CHK(rdat, hi[j]);
         `CHK(TIMESTAMP_O, ts_exp);
      end
   endtask
   // Refused accesses must leave nothing behind
   task automatic bad_access();
      apb(1'b1, 8'h81, 32'hFFFF_FFFF);
      `CHK(rerr, 1'b1);
      apb(1'b0, 8'h81, 32'h0);
      `CHK(rerr, 1'b1);
      `CHK(rdat, UNMAPPED_DATA);
      apb(1'b0, ADDR_PAYLOAD, 32'h0);
      `CHK(rdat, 32'h0);
   endtask
   task automatic bad_size();
      frame(12'h0FF, 1'b1);
      `CHK(FRAME_INVALID_O, 1'b1);
      `CHK(seen_v, 1'b0);
      apb(1'b0, ADDR_CLASS, 32'h0);
      `CHK(rdat[2:0], 3'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (fail_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      RSTN_I = 1'b0;
      PSEL_I = 1'b0;
      PENABLE_I = 1'b0;
      PWRITE_I = 1'b0;
      PADDR_I = 8'h00;
      PWDATA_I = 32'h0;
      seen_v = 1'b0;
      ts_exp = TS_RESET;
      head = 5'h00;
      offs = 2'h0;
      kind = 3'h0;
      repeat (12) @(posedge CLK_I);
      RSTN_I <= 1'b1;
      reset_vals();
      cls_table();
      chan_aware();
      silence_desc();
      bad_access();
      bad_size();
      results();
   end
endmodule // tb_top
